//--- src/mbsp_pkg.sv
/*
 * Package for the memory boundary scan port: chain length, reserved
 * chain positions, pad word layout and the control carrier struct.
 * Assumes a single 10 MHz core clock and all pins sampled by it.
 */
package mbsp_pkg;
    localparam int unsigned MBSP_CHAIN_LEN = 67;
    // chain positions are numbered 1..67 in exit order, stored at index n-1
    localparam int unsigned MBSP_RSVD_POS_A = 57;
    localparam int unsigned MBSP_RSVD_POS_B = 58;
    localparam int unsigned MBSP_FIFO_WIDTH = 1;
    localparam int unsigned MBSP_FIFO_DEPTH = 16;
    localparam logic MBSP_TAIL_FILL = 1'b0;
    localparam logic MBSP_ZERO = 1'b0;

    typedef logic [MBSP_CHAIN_LEN-1:0] mbsp_chain_t;

    // synchronised tester controls, carried together
    typedef struct packed {
        logic mode;
        logic shift;
        logic strobe;
        logic gate;
    } mbsp_ctl_t;

    typedef enum logic [1:0] {
        MBSP_ST_NORMAL = 2'b00,
        MBSP_ST_SCAN = 2'b01,
        MBSP_ST_LOCKED = 2'b11
    } mbsp_state_t;
endpackage : mbsp_pkg

//--- src/mbsp_sync.sv
/*
 * Two-flop synchroniser for one pin level.
 * Assumes d comes from outside the clk domain; only q may be read.
 */
module mbsp_sync (
    input wire logic clk,
    input wire logic srst,
    input wire logic d,
    output logic q
);
    logic meta_r;
    logic meta_nxt;
    logic q_r;
    logic q_nxt;

    // first flop feeds the second only
    always_comb begin
        meta_nxt = d;
        q_nxt = meta_r;
        if (srst) begin
            meta_nxt = 1'b0;
            q_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        meta_r <= meta_nxt;
        q_r <= q_nxt;
    end

    assign q = q_r;
endmodule : mbsp_sync

//--- src/mbsp_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; depth is a power of two.
 */
module mbsp_fifo #(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wr_r;
    logic [AW:0] wr_nxt;
    logic [AW:0] rd_r;
    logic [AW:0] rd_nxt;
    logic push;
    logic pop;
    logic full;
    logic empty;

    // extra pointer bit tells full from empty
    assign full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
    assign empty = (wr_r == rd_r);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_r[rd_r[AW-1:0]];
    assign push = in_valid && !full;
    assign pop = out_ready && !empty;

    always_comb begin
        wr_nxt = wr_r;
        rd_nxt = rd_r;
        if (push) begin
            wr_nxt = wr_r + (AW+1)'(1);
        end
        if (pop) begin
            rd_nxt = rd_r + (AW+1)'(1);
        end
        if (srst) begin
            wr_nxt = '0;
            rd_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        wr_r <= wr_nxt;
        rd_r <= rd_nxt;
        if (push) begin
            mem_r[wr_r[AW-1:0]] <= in_data;
        end
    end
endmodule : mbsp_fifo

//--- src/mbsp_scan_port.sv
/*
 * Boundary scan port of the memory device: capture of pad levels into a
 * 67-position chain, serial shift-out on the lane-0 write strobe pin,
 * and suppression of normal functions while scan mode is selected.
 * Assumes every tester and normal-function pin is asynchronous to clk
 * (10 MHz), that the scan strobe stays high and low for at least four
 * clk periods, and that the controls settle three periods before it rises.
 */
// Summary of operation
// - scan mode follows scan-mode select level
// - select low captures pads, high shifts chain
// - inputs sampled on scan strobe rising edge
// - strobe may be single or irregular pulses
// - serial output driven only when gate high
// - serial data out on lane-0 write strobe
// - 67 positions, then zeros from grounded tail
// - reserved-ball positions always read zero
// - ball mirroring disabled during scan
// - no commands executed while scan selected
// - scan sets nominal C/A termination, DQ off
// - leaving scan needs power cycle, re-init
// - scan not yet selected since reset: borrowed pins act normally
module mbsp_scan_port (
    clk,
    srst,
    scan_mode_select,
    capture_shift_select,
    scan_strobe,
    scan_output_gate,
    pad_in,
    init_reset_input,
    ball_mirror_select,
    chip_select_n,
    strobe_lane0_core_out,
    strobe_lane0_core_oe_n,
    write_strobe_lane0_out,
    write_strobe_lane0_oe_n,
    reset_to_core,
    mirror_to_core,
    chip_select_n_to_core,
    cmd_enable,
    ca_term_nominal,
    dq_term_disable,
    scan_active,
    shift_count
);
    input wire logic clk;
    input wire logic srst;
    input wire logic scan_mode_select;
    input wire logic capture_shift_select;
    input wire logic scan_strobe;
    input wire logic scan_output_gate;
    input wire mbsp_pkg::mbsp_chain_t pad_in;
    input wire logic init_reset_input;
    input wire logic ball_mirror_select;
    input wire logic chip_select_n;
    input wire logic strobe_lane0_core_out;
    input wire logic strobe_lane0_core_oe_n;
    output logic write_strobe_lane0_out;
    output logic write_strobe_lane0_oe_n;
    output logic reset_to_core;
    output logic mirror_to_core;
    output logic chip_select_n_to_core;
    output logic cmd_enable;
    output logic ca_term_nominal;
    output logic dq_term_disable;
    output logic scan_active;
    output logic [7:0] shift_count;

    mbsp_pkg::mbsp_ctl_t ctl_s;
    mbsp_pkg::mbsp_chain_t pad_s;
    logic strobe_d_r;
    logic strobe_d_nxt;
    logic strobe_rise;
    mbsp_pkg::mbsp_state_t state_r;
    mbsp_pkg::mbsp_state_t state_nxt;
    mbsp_pkg::mbsp_chain_t chain_r;
    mbsp_pkg::mbsp_chain_t chain_nxt;
    logic gate_r;
    logic gate_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic scan_serial_out_r;
    logic scan_serial_out_nxt;
    logic scan_serial_out_oe_n_r;
    logic scan_serial_out_oe_n_nxt;
    logic rst_o_r;
    logic mir_o_r;
    logic cs_o_r;
    logic cmd_r;
    logic cat_r;
    logic dqt_r;
    logic rst_o_nxt;
    logic mir_o_nxt;
    logic cs_o_nxt;
    logic cmd_nxt;
    logic cat_nxt;
    logic dqt_nxt;
    logic rst_s;
    logic mir_s;
    logic cs_s;
    logic scan_act_r;
    logic scan_act_nxt;

    // tester pins are asynchronous: two flops each before any use
    mbsp_sync u_sync_mode (
        .clk(clk),
        .srst(srst),
        .d(scan_mode_select),
        .q(ctl_s.mode)
    );
    mbsp_sync u_sync_shift (
        .clk(clk),
        .srst(srst),
        .d(capture_shift_select),
        .q(ctl_s.shift)
    );
    mbsp_sync u_sync_strobe (
        .clk(clk),
        .srst(srst),
        .d(scan_strobe),
        .q(ctl_s.strobe)
    );
    mbsp_sync u_sync_gate (
        .clk(clk),
        .srst(srst),
        .d(scan_output_gate),
        .q(ctl_s.gate)
    );

    // normal-function pins are asynchronous too; core sees them late
    mbsp_sync u_sync_rst (
        .clk(clk),
        .srst(srst),
        .d(init_reset_input),
        .q(rst_s)
    );
    mbsp_sync u_sync_mir (
        .clk(clk),
        .srst(srst),
        .d(ball_mirror_select),
        .q(mir_s)
    );
    mbsp_sync u_sync_cs (
        .clk(clk),
        .srst(srst),
        .d(chip_select_n),
        .q(cs_s)
    );

    // pads synchronised too; their value is settled before the strobe edge
    genvar gi;
    generate
        for (gi = 0; gi < mbsp_pkg::MBSP_CHAIN_LEN; gi++) begin : g_pad
            mbsp_sync u_sync_pad (
                .clk(clk),
                .srst(srst),
                .d(pad_in[gi]),
                .q(pad_s[gi])
            );
        end
    endgenerate

    // edge finder on the synchronised strobe; no free-running clock assumed
    assign strobe_rise = ctl_s.strobe && !strobe_d_r;
    always_comb begin
        strobe_d_nxt = srst ? 1'b0 : ctl_s.strobe;
    end
    always_ff @(posedge clk) begin
        strobe_d_r <= strobe_d_nxt;
    end

    // mode tracking; once scanned, normal service waits for a power cycle
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            mbsp_pkg::MBSP_ST_NORMAL: begin
                if (ctl_s.mode) begin
                    state_nxt = mbsp_pkg::MBSP_ST_SCAN;
                end
            end
            mbsp_pkg::MBSP_ST_SCAN: begin
                if (!ctl_s.mode) begin
                    state_nxt = mbsp_pkg::MBSP_ST_LOCKED;
                end
            end
            mbsp_pkg::MBSP_ST_LOCKED: begin
                if (ctl_s.mode) begin
                    state_nxt = mbsp_pkg::MBSP_ST_SCAN;
                end
            end
            default: state_nxt = mbsp_pkg::MBSP_ST_NORMAL;
        endcase
        if (srst) begin
            state_nxt = mbsp_pkg::MBSP_ST_NORMAL;
        end
        // flag registered beside the state so the output leaves a flop
        scan_act_nxt = (state_nxt == mbsp_pkg::MBSP_ST_SCAN);
    end

    always_ff @(posedge clk) begin
        state_r <= state_nxt;
        scan_act_r <= scan_act_nxt;
    end

    // chain: parallel capture or one-step shift per strobe edge
    always_comb begin
        chain_nxt = chain_r;
        gate_nxt = gate_r;
        cnt_nxt = cnt_r;
        if (state_r == mbsp_pkg::MBSP_ST_SCAN && strobe_rise) begin
            gate_nxt = ctl_s.gate;
            if (!ctl_s.shift) begin
                chain_nxt = pad_s;
                // reserved balls zeroed at capture only, so that later
                // positions still pass through these places on the way out
                chain_nxt[mbsp_pkg::MBSP_RSVD_POS_A-1] = mbsp_pkg::MBSP_ZERO;
                chain_nxt[mbsp_pkg::MBSP_RSVD_POS_B-1] = mbsp_pkg::MBSP_ZERO;
                cnt_nxt = '0;
            end else if (fifo_in_ready) begin
                // position 1 leaves first; tail fills with ground
                chain_nxt = {mbsp_pkg::MBSP_TAIL_FILL,
                    chain_r[mbsp_pkg::MBSP_CHAIN_LEN-1:1]};
                // count saturates rather than wrapping back to zero
                if (cnt_r != '1) begin
                    cnt_nxt = cnt_r + 8'h01;
                end
            end
        end
        if (srst) begin
            chain_nxt = '0;
            gate_nxt = 1'b0;
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        chain_r <= chain_nxt;
        gate_r <= gate_nxt;
        cnt_r <= cnt_nxt;
    end

    // each shifted bit passes the FIFO; a full FIFO holds the shift off
    // the reader never stalls, so at most one entry is ever held
    assign fifo_in_valid = state_r == mbsp_pkg::MBSP_ST_SCAN && strobe_rise && ctl_s.shift;
    assign fifo_out_ready = 1'b1;

    mbsp_fifo #(
        .WIDTH(mbsp_pkg::MBSP_FIFO_WIDTH),
        .DEPTH(mbsp_pkg::MBSP_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .srst(srst),
        .in_data(chain_r[1]),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready)
    );

    // lane-0 write strobe pin: scan data in scan, core strobe in normal, released while locked
    // capture bypasses the FIFO: position 1 is on the pin before any shift
    always_comb begin
        scan_serial_out_nxt = scan_serial_out_r;
        scan_serial_out_oe_n_nxt = 1'b1;
        if (state_r == mbsp_pkg::MBSP_ST_SCAN) begin
            if (fifo_out_valid) begin
                scan_serial_out_nxt = fifo_out_data;
            end else if (strobe_rise && !ctl_s.shift) begin
                scan_serial_out_nxt = pad_s[0]; // capture presents position 1
            end
            scan_serial_out_oe_n_nxt = !gate_r;
        end else if (state_r == mbsp_pkg::MBSP_ST_NORMAL) begin
            scan_serial_out_nxt = strobe_lane0_core_out;
            scan_serial_out_oe_n_nxt = strobe_lane0_core_oe_n;
        end
        if (srst) begin
            scan_serial_out_nxt = 1'b0;
            scan_serial_out_oe_n_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        scan_serial_out_r <= scan_serial_out_nxt;
        scan_serial_out_oe_n_r <= scan_serial_out_oe_n_nxt;
    end

    // borrowed pins and core controls; scan overrides normal function
    // pins reach the core three clocks after they change
    always_comb begin
        rst_o_nxt = rst_s;
        mir_o_nxt = mir_s;
        cs_o_nxt = cs_s;
        cmd_nxt = 1'b1;
        cat_nxt = 1'b0;
        dqt_nxt = 1'b0;
        if (state_r != mbsp_pkg::MBSP_ST_NORMAL || ctl_s.mode) begin
            mir_o_nxt = 1'b0;
            cs_o_nxt = 1'b1;
            cmd_nxt = 1'b0;
            cat_nxt = 1'b1;
            dqt_nxt = 1'b1;
            rst_o_nxt = rst_o_r;
        end
        if (srst) begin
            rst_o_nxt = 1'b0;
            mir_o_nxt = 1'b0;
            cs_o_nxt = 1'b1;
            cmd_nxt = 1'b0;
            cat_nxt = 1'b0;
            dqt_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        rst_o_r <= rst_o_nxt;
        mir_o_r <= mir_o_nxt;
        cs_o_r <= cs_o_nxt;
        cmd_r <= cmd_nxt;
        cat_r <= cat_nxt;
        dqt_r <= dqt_nxt;
    end

    assign write_strobe_lane0_out = scan_serial_out_r;
    assign write_strobe_lane0_oe_n = scan_serial_out_oe_n_r;
    assign reset_to_core = rst_o_r;
    assign mirror_to_core = mir_o_r;
    assign chip_select_n_to_core = cs_o_r;
    assign cmd_enable = cmd_r;
    assign ca_term_nominal = cat_r;
    assign dq_term_disable = dqt_r;
    assign scan_active = scan_act_r;
    assign shift_count = cnt_r;
endmodule : mbsp_scan_port

//--- verif/mbsp_tester.sv
/*
 * Tester model for the scan pins: mode, capture/shift, strobe, gate.
 * Assumes the 100 ns bench clock; strobe pulses are 400 ns high, one per 1200 ns or more.
 */
module mbsp_tester (
    input wire logic clk,
    output logic scan_mode_select,
    output logic capture_shift_select,
    output logic scan_strobe,
    output logic scan_output_gate
);
    timeunit 1ns;
    timeprecision 1ns;
    // strobe stands still between frames, gate starts low and holds its last pulse level
    initial begin
        scan_mode_select = 1'b0;
        capture_shift_select = 1'b0;
        scan_strobe = 1'b0;
        scan_output_gate = 1'b0;
    end
    // level change, then room for the sync flops and the state flop
    task automatic set_mode(input logic v);
        @(posedge clk);
        scan_mode_select <= v;
        repeat (6) @(posedge clk);
    endtask : set_mode
    // one strobe pulse; gap stretches set-up so trains are irregular
    task automatic pulse(input logic s, input logic g, input int gap);
        @(posedge clk);
        capture_shift_select <= s;
        scan_output_gate <= g;
        repeat (3 + gap) @(posedge clk);
        scan_strobe <= 1'b1;
        repeat (4) @(posedge clk);
        scan_strobe <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : pulse
endmodule : mbsp_tester

//--- verif/mbsp_scan_port_sva.sv
/*
 * Checker for the scan port, bound to its top-level ports.
 * Assumes one clock domain and srst as its synchronous reset.
 */
module mbsp_scan_port_sva (
    input wire logic clk,
    input wire logic srst,
    input wire logic scan_mode_select,
    input wire logic scan_output_gate,
    input wire logic init_reset_input,
    input wire logic ball_mirror_select,
    input wire logic chip_select_n,
    input wire logic write_strobe_lane0_out,
    input wire logic write_strobe_lane0_oe_n,
    input wire logic reset_to_core,
    input wire logic mirror_to_core,
    input wire logic chip_select_n_to_core,
    input wire logic cmd_enable,
    input wire logic ca_term_nominal,
    input wire logic dq_term_disable,
    input wire logic scan_active,
    input wire logic [7:0] shift_count
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    AST_ENTER: assert property (scan_mode_select [*6] |-> scan_active)
        else $error("scan mode not entered");
    AST_LEAVE: assert property (!scan_mode_select [*6] |-> !scan_active)
        else $error("scan mode not left");
    AST_NO_CMD: assert property ($past(scan_active) && scan_active |-> !cmd_enable)
        else $error("commands enabled in scan");
    AST_SCAN_PINS: assert property ($past(scan_active) && scan_active
        |-> !mirror_to_core && ca_term_nominal && dq_term_disable)
        else $error("mirror or termination wrong in scan");
    AST_PASS: assert property (cmd_enable && $past(cmd_enable)
        && $past(cmd_enable, 2) && $past(cmd_enable, 3)
        |-> reset_to_core == $past(init_reset_input, 3)
        && mirror_to_core == $past(ball_mirror_select, 3)
        && chip_select_n_to_core == $past(chip_select_n, 3))
        else $error("normal pin not passed through");
    AST_GATE: assert property (scan_active && $fell(write_strobe_lane0_oe_n)
        |-> $past(scan_output_gate, 2))
        else $error("serial output driven with gate low");
    AST_ONE_STEP: assert property (scan_active && $changed(shift_count)
        |-> shift_count == $past(shift_count) + 8'h01 || shift_count == 8'h00)
        else $error("chain advanced by more than one");
    AST_LOCK: assert property ($fell(scan_active)
        |=> (!cmd_enable && write_strobe_lane0_oe_n) [*8])
        else $error("normal service resumed without reset");
    AST_TAIL: assert property (scan_active && shift_count >= 8'h44
        && !write_strobe_lane0_oe_n |-> !write_strobe_lane0_out)
        else $error("tail of chain not zero");
endmodule : mbsp_scan_port_sva

bind mbsp_scan_port mbsp_scan_port_sva u_sva (.clk, .srst, .scan_mode_select,
    .scan_output_gate, .init_reset_input, .ball_mirror_select, .chip_select_n,
    .write_strobe_lane0_out, .write_strobe_lane0_oe_n, .reset_to_core,
    .mirror_to_core, .chip_select_n_to_core, .cmd_enable, .ca_term_nominal,
    .dq_term_disable, .scan_active, .shift_count);

//--- verif/mbsp_scan_port_tb_top.sv
/*
 * Self-checking bench for the scan port and its FIFO.
 * Assumes the package, design files and tester model compile first.
 */
module mbsp_scan_port_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam mbsp_pkg::mbsp_chain_t PAT = 67'h7_9bd1_35e2_c48f_a6f3;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic init_reset_input = 1'b0;
    logic ball_mirror_select = 1'b0;
    logic chip_select_n = 1'b1;
    logic strobe_lane0_core_out = 1'b0;
    logic strobe_lane0_core_oe_n = 1'b1;
    mbsp_pkg::mbsp_chain_t pad_in = PAT;
    logic scan_mode_select, capture_shift_select, scan_strobe, scan_output_gate;
    logic write_strobe_lane0_out, write_strobe_lane0_oe_n, reset_to_core;
    logic mirror_to_core, chip_select_n_to_core, cmd_enable, ca_term_nominal;
    logic dq_term_disable, scan_active;
    logic [7:0] shift_count;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;

    always #50 clk = ~clk;

    mbsp_tester tester (.clk, .scan_mode_select, .capture_shift_select,
        .scan_strobe, .scan_output_gate);
    mbsp_scan_port uut (.clk, .srst, .scan_mode_select, .capture_shift_select,
        .scan_strobe, .scan_output_gate, .pad_in, .init_reset_input,
        .ball_mirror_select, .chip_select_n, .strobe_lane0_core_out,
        .strobe_lane0_core_oe_n, .write_strobe_lane0_out, .write_strobe_lane0_oe_n,
        .reset_to_core, .mirror_to_core, .chip_select_n_to_core, .cmd_enable,
        .ca_term_nominal, .dq_term_disable, .scan_active, .shift_count);

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // expected pin bit for exit position n, zeros past the tail
    function automatic logic exp_bit(input mbsp_pkg::mbsp_chain_t p, input int n);
        if (n > 67 || n == 57 || n == 58) return 1'b0;
        return p[n-1];
    endfunction : exp_bit

    task automatic complete_run();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    // borrowed pins act normally; a strobe outside scan is ignored
    task automatic t_normal();
        chk("cmd_enable", 8'h01, cmd_enable);
        init_reset_input <= 1'b1;
        ball_mirror_select <= 1'b1;
        chip_select_n <= 1'b0;
        strobe_lane0_core_out <= 1'b1;
        strobe_lane0_core_oe_n <= 1'b0;
        tester.pulse(1'b1, 1'b1, 0);
        chk("reset_to_core", 8'h01, reset_to_core);
        chk("mirror_to_core", 8'h01, mirror_to_core);
        chk("cs_to_core", 8'h00, chip_select_n_to_core);
        chk("lane0_out", 8'h01, write_strobe_lane0_out);
        chk("lane0_oe_n", 8'h00, write_strobe_lane0_oe_n);
        chk("shift_count", 8'h00, shift_count);
        chk("terms normal", 8'h00, {ca_term_nominal, dq_term_disable});
        $display("test normal done");
    endtask : t_normal

    // capture, shift past the tail with irregular gaps, gate off, recapture
    task automatic t_scan();
        tester.set_mode(1'b1);
        chk("scan_active", 8'h01, scan_active);
        chk("cmd_enable", 8'h00, cmd_enable);
        chk("mirror", 8'h00, mirror_to_core);
        chk("terms", 8'h03, {ca_term_nominal, dq_term_disable});
        tester.pulse(1'b0, 1'b1, 0);
        chk("pos1", exp_bit(PAT, 1), write_strobe_lane0_out);
        chk("oe_n", 8'h00, write_strobe_lane0_oe_n);
        for (int k = 1; k <= 70; k++) begin
            tester.pulse(1'b1, 1'b1, k % 3);
            chk("chain bit", exp_bit(PAT, k + 1), write_strobe_lane0_out);
            chk("shift_count", k[7:0], shift_count);
        end
        pad_in <= ~PAT;
        tester.pulse(1'b1, 1'b0, 0);
        chk("oe_n gated", 8'h01, write_strobe_lane0_oe_n);
        tester.pulse(1'b0, 1'b1, 0);
        chk("recapture", exp_bit(~PAT, 1), write_strobe_lane0_out);
        chk("count clear", 8'h00, shift_count);
        tester.pulse(1'b1, 1'b1, 0);
        chk("recap pos2", exp_bit(~PAT, 2), write_strobe_lane0_out);
        $display("test scan done");
    endtask : t_scan

    // leaving scan locks the part until a reset stands in for power cycle
    task automatic t_exit();
        tester.set_mode(1'b0);
        chk("scan_active", 8'h00, scan_active);
        chk("locked cmd", 8'h00, cmd_enable);
        chk("locked oe_n", 8'h01, write_strobe_lane0_oe_n);
        repeat (8) @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("cmd after reset", 8'h01, cmd_enable);
        $display("test exit done");
    endtask : t_exit

    // fresh entry after reset; back-to-back shifts stream through the FIFO
    task automatic t_stream();
        tester.set_mode(1'b1);
        tester.pulse(1'b0, 1'b1, 0);
        chk("stream pos1", exp_bit(~PAT, 1), write_strobe_lane0_out);
        repeat (20) tester.pulse(1'b1, 1'b1, 0);
        chk("stream pos21", exp_bit(~PAT, 21), write_strobe_lane0_out);
        chk("stream count", 8'h14, shift_count);
        $display("test stream done");
    endtask : t_stream

    // cycle ceiling well above the roughly 1260 cycles of the tests
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            complete_run();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        chk("reset oe_n", 8'h01, write_strobe_lane0_oe_n);
        chk("reset cs", 8'h01, chip_select_n_to_core);
        chk("reset cmd", 8'h00, cmd_enable);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        t_normal();
        t_scan();
        t_exit();
        t_stream();
        complete_run();
    end
endmodule : mbsp_scan_port_tb_top
